// >>> pll_readback_status.sv
// axi4-lite register bank for pll readback status, threshold select and change interrupts
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "pll_status_params.svh"

// Function
// - bit 4 shows which reference feeds the pll, 1 means the second
// - bit 3 reads 1 while vco frequency is above its threshold
// - bit 2 reads 1 while second reference frequency is above threshold
// - second reference threshold is chosen by bit 6 of register 0x1A
// - bit 1 reads 1 while first reference frequency is above threshold
// - first reference monitor uses the same bit 6 threshold selection
// - bit 0 copies the digital lock detector, 1 while locked
module pll_readback_status
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`AXI_DATA_W-1:0] wdata,
    input wire logic [`AXI_STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [`AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic refSecondSelected,
    input wire logic vcoAboveThreshold,
    input wire logic secondRefAboveThreshold,
    input wire logic firstRefAboveThreshold,
    input wire logic digitalLockDetect,
    output logic refThresholdSelect,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [`REG_IDX_W-1:0] regIndex(input logic [`AXI_ADDR_W-1:0] addr);
        regIndex = addr[`REG_IDX_W+1:2];
    endfunction

    function automatic logic isMapped(input logic [`REG_IDX_W-1:0] idx);
        isMapped = (idx == `THRESH_CFG_IDX) || (idx == `PLL_STATUS_IDX)
            || (idx == `IRQ_STATUS_IDX) || (idx == `IRQ_MASK_IDX);
    endfunction

    function automatic logic [1:0] respFor(input logic [`REG_IDX_W-1:0] idx);
        respFor = isMapped(idx) ? `RESP_OKAY : `RESP_SLVERR;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // live status synchronisation

    logic [`LIVE_W-1:0] statusIn;
    logic [`LIVE_W-1:0] liveStatus;
    logic [`LIVE_W-1:0] livePrev;

    // monitors run on reference and vco clocks, so bring them over first
    assign statusIn[`REFSEL_BIT] = refSecondSelected;
    assign statusIn[`VCO_ABOVE_BIT] = vcoAboveThreshold;
    assign statusIn[`SECOND_REFERENCE_INPUT_ABOVE_BIT] = secondRefAboveThreshold;
    assign statusIn[`FIRST_REFERENCE_INPUT_ABOVE_BIT] = firstRefAboveThreshold;
    assign statusIn[`LOCK_BIT] = digitalLockDetect;

    pll_status_sync #(
        .WIDTH(`LIVE_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(statusIn),
        .syncOut(liveStatus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // write channel

    pll_status_pkg::wr_state_t wrState;
    pll_status_pkg::wr_state_t next_wrState;
    logic awHeld;
    logic wHeld;
    logic [`AXI_ADDR_W-1:0] awAddrQ;
    logic [`AXI_DATA_W-1:0] wDataQ;
    logic [`AXI_STRB_W-1:0] wStrbQ;

    logic awFire;
    logic wFire;
    logic doWrite;
    logic next_awHeld;
    logic next_wHeld;
    logic next_awready;
    logic next_wready;
    logic [`REG_IDX_W-1:0] wrIdx;
    logic cfgWrite;
    logic irqClearWrite;
    logic maskWrite;
    logic statusWrite;

    assign awFire = awvalid && awready;
    assign wFire = wvalid && wready;
    assign doWrite = awHeld && wHeld && (wrState == pll_status_pkg::WR_IDLE);
    assign next_awHeld = awFire || (awHeld && !doWrite);
    assign next_wHeld = wFire || (wHeld && !doWrite);
    assign wrIdx = regIndex(awAddrQ);
    assign cfgWrite = doWrite && (wrIdx == `THRESH_CFG_IDX) && wStrbQ[0];
    assign irqClearWrite = doWrite && (wrIdx == `IRQ_STATUS_IDX) && wStrbQ[0];
    assign maskWrite = doWrite && (wrIdx == `IRQ_MASK_IDX) && wStrbQ[0];
    // status is read only, a write there only earns an okay
    assign statusWrite = doWrite && (wrIdx == `PLL_STATUS_IDX);

    always_comb
    begin
        next_wrState = wrState;
        case (wrState)
            pll_status_pkg::WR_IDLE:
            begin
                if (doWrite)
                begin
                    next_wrState = pll_status_pkg::WR_RESP;
                end
            end
            pll_status_pkg::WR_RESP:
            begin
                if (bready)
                begin
                    next_wrState = pll_status_pkg::WR_IDLE;
                end
            end
            default:
            begin
                next_wrState = pll_status_pkg::WR_IDLE;
            end
        endcase
    end

    // one write in flight; address and data refused until the response is taken
    assign next_awready = !next_awHeld && (next_wrState == pll_status_pkg::WR_IDLE);
    assign next_wready = !next_wHeld && (next_wrState == pll_status_pkg::WR_IDLE);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrState <= pll_status_pkg::WR_IDLE;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end
        else
        begin
            wrState <= next_wrState;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= (next_wrState == pll_status_pkg::WR_RESP);
            if (doWrite)
            begin
                bresp <= respFor(wrIdx);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
        end
        else
        begin
            if (awFire)
            begin
                awAddrQ <= awaddr;
            end
            if (wFire)
            begin
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration and interrupt registers

    logic [`LIVE_W-1:0] irqStatus;
    logic [`LIVE_W-1:0] irqMask;
    logic [`LIVE_W-1:0] liveChange;
    logic [`LIVE_W-1:0] clearBits;
    logic [`LIVE_W-1:0] next_irqStatus;

    assign liveChange = liveStatus ^ livePrev;
    assign clearBits = irqClearWrite ? wDataQ[`LIVE_W-1:0] : '0;
    // a change landing with its own clear stays set
    assign next_irqStatus = (irqStatus & ~clearBits) | liveChange;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            refThresholdSelect <= `THRESH_SEL_RST;
            irqMask <= `IRQ_MASK_RST;
            irqStatus <= `IRQ_STATUS_RST;
            livePrev <= `LIVE_RST;
            irq <= 1'b0;
        end
        else
        begin
            if (cfgWrite)
            begin
                // one select serves both reference monitors
                refThresholdSelect <= wDataQ[`THRESH_SEL_BIT];
            end
            if (maskWrite)
            begin
                irqMask <= wDataQ[`LIVE_W-1:0];
            end
            irqStatus <= next_irqStatus;
            livePrev <= liveStatus;
            irq <= |(irqStatus & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel

    pll_status_pkg::rd_state_t rdState;
    pll_status_pkg::rd_state_t next_rdState;
    logic arFire;
    logic [`REG_IDX_W-1:0] arIdx;
    logic [`AXI_DATA_W-1:0] cfgWord;
    logic [`AXI_DATA_W-1:0] readWord;

    assign arFire = arvalid && arready;
    assign arIdx = regIndex(araddr);

    always_comb
    begin
        cfgWord = '0;
        cfgWord[`THRESH_SEL_BIT] = refThresholdSelect;
    end

    // status is sampled live at the address handshake; unused bits read zero
    assign readWord = (arIdx == `PLL_STATUS_IDX) ? `AXI_DATA_W'(liveStatus)
        : (arIdx == `THRESH_CFG_IDX) ? cfgWord
        : (arIdx == `IRQ_STATUS_IDX) ? `AXI_DATA_W'(irqStatus)
        : (arIdx == `IRQ_MASK_IDX) ? `AXI_DATA_W'(irqMask)
        : '0;

    always_comb
    begin
        next_rdState = rdState;
        case (rdState)
            pll_status_pkg::RD_IDLE:
            begin
                if (arFire)
                begin
                    next_rdState = pll_status_pkg::RD_RESP;
                end
            end
            pll_status_pkg::RD_RESP:
            begin
                if (rready)
                begin
                    next_rdState = pll_status_pkg::RD_IDLE;
                end
            end
            default:
            begin
                next_rdState = pll_status_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdState <= pll_status_pkg::RD_IDLE;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `RESP_OKAY;
        end
        else
        begin
            rdState <= next_rdState;
            arready <= (next_rdState == pll_status_pkg::RD_IDLE);
            rvalid <= (next_rdState == pll_status_pkg::RD_RESP);
            if (arFire)
            begin
                rdata <= readWord;
                rresp <= respFor(arIdx);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    logic statusRead;
    assign statusRead = arFire && (arIdx == `PLL_STATUS_IDX);

    a_refsel_readback: assert property (@(posedge clk) disable iff (!rst_n)
        statusRead |=> rdata[`REFSEL_BIT] == $past(liveStatus[`REFSEL_BIT]))
        else $error("reference select bit not returned by status read");

    a_vco_thresh_readback: assert property (@(posedge clk) disable iff (!rst_n)
        statusRead ##1 1'b1 |-> rvalid && rdata[`VCO_ABOVE_BIT] == $past(statusIn[`VCO_ABOVE_BIT], 3))
        else $error("vco threshold bit wrong on status read");

    a_second_reference_input_thresh_readback: assert property (@(posedge clk) disable iff (!rst_n)
        statusRead |=> rdata[`SECOND_REFERENCE_INPUT_ABOVE_BIT] == $past(liveStatus[`SECOND_REFERENCE_INPUT_ABOVE_BIT])
            && rresp == `RESP_OKAY)
        else $error("second reference threshold bit wrong on status read");

    a_thresh_select_write: assert property (@(posedge clk) disable iff (!rst_n)
        cfgWrite |=> refThresholdSelect == $past(wDataQ[`THRESH_SEL_BIT]) && bvalid)
        else $error("threshold select not taken from configuration write");

    a_first_reference_input_thresh_readback: assert property (@(posedge clk) disable iff (!rst_n)
        statusRead |=> rdata[`FIRST_REFERENCE_INPUT_ABOVE_BIT] == $past(liveStatus[`FIRST_REFERENCE_INPUT_ABOVE_BIT]))
        else $error("first reference threshold bit wrong on status read");

    a_thresh_select_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !cfgWrite |=> $stable(refThresholdSelect))
        else $error("threshold select changed without configuration write");

    a_lock_readback: assert property (@(posedge clk) disable iff (!rst_n)
        statusRead |=> rdata[`LOCK_BIT] == $past(liveStatus[`LOCK_BIT]) && rvalid)
        else $error("lock detect bit wrong on status read");

    a_status_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        statusWrite |=> bvalid && bresp == `RESP_OKAY && $stable(refThresholdSelect)
            && $stable(irqMask))
        else $error("write to read only status had an effect");

    a_sync_latency: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(rst_n, 2) |-> liveStatus == $past(statusIn, 2))
        else $error("live status not two cycles behind monitor inputs");

    a_change_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (liveChange != '0) |=> (irqStatus & $past(liveChange)) == $past(liveChange))
        else $error("status change lost from interrupt flags");

    a_irq_follows_mask: assert property (@(posedge clk) disable iff (!rst_n)
        ((irqStatus & irqMask) != '0) |=> irq)
        else $error("interrupt not raised for unmasked flag");

endmodule

// >>> pll_status_params.svh
// register map, field positions, reset values and bus codes of the pll readback status block
`ifndef PLL_STATUS_PARAMS_SVH
`define PLL_STATUS_PARAMS_SVH

`define AXI_ADDR_W 8
`define AXI_DATA_W 32
`define AXI_STRB_W 4
`define REG_IDX_W 6

// register indices; byte address is four times the index
`define THRESH_CFG_IDX 6'h1a
`define PLL_STATUS_IDX 6'h1f
`define IRQ_STATUS_IDX 6'h20
`define IRQ_MASK_IDX 6'h21

// live status field positions
`define LIVE_W 5
`define REFSEL_BIT 4
`define VCO_ABOVE_BIT 3
`define SECOND_REFERENCE_INPUT_ABOVE_BIT 2
`define FIRST_REFERENCE_INPUT_ABOVE_BIT 1
`define LOCK_BIT 0

// threshold configuration field and register reset values
`define THRESH_SEL_BIT 6
`define THRESH_SEL_RST 1'h0
`define IRQ_MASK_RST 5'h00
`define IRQ_STATUS_RST 5'h00
`define LIVE_RST 5'h00

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> pll_status_pkg.sv
// types shared by the pll readback status block
package pll_status_pkg;

    typedef enum logic {WR_IDLE, WR_RESP} wr_state_t;

    typedef enum logic {RD_IDLE, RD_RESP} rd_state_t;

endpackage

// >>> pll_status_sync.sv
// two-flop level synchroniser for the pll monitor and lock detect levels
`timescale 1ns/10ps
`include "pll_status_params.svh"

module pll_status_sync
#(
    parameter int WIDTH = `LIVE_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    // first stage feeds only the second stage
    logic [WIDTH-1:0] stageOne;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stageOne <= '0;
            syncOut <= '0;
        end
        else
        begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end

endmodule

// >>> tb_top.sv
// self-checking testbench for the pll readback status register bank
`timescale 1ns/10ps
`include "pll_status_params.svh"

`define CHECK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb_top;

logic clk;
logic rst_n;
logic [`AXI_ADDR_W-1:0] awaddr;
logic awvalid;
logic awready;
logic [`AXI_DATA_W-1:0] wdata;
logic [`AXI_STRB_W-1:0] wstrb;
logic wvalid;
logic wready;
logic [1:0] bresp;
logic bvalid;
logic bready;
logic [`AXI_ADDR_W-1:0] araddr;
logic arvalid;
logic arready;
logic [`AXI_DATA_W-1:0] rdata;
logic [1:0] rresp;
logic rvalid;
logic rready;
logic [`LIVE_W-1:0] liveDrive;
logic refThresholdSelect;
logic irq;
int err_count;
int n_checks;

localparam logic [7:0] CFG_ADDR = {`THRESH_CFG_IDX, 2'h0};
localparam logic [7:0] STAT_ADDR = {`PLL_STATUS_IDX, 2'h0};
localparam logic [7:0] IST_ADDR = {`IRQ_STATUS_IDX, 2'h0};
localparam logic [7:0] IMSK_ADDR = {`IRQ_MASK_IDX, 2'h0};
localparam logic [7:0] BAD_ADDR = 8'hfc;

pll_readback_status u_pll_readback_status (
    .clk(clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .refSecondSelected(liveDrive[`REFSEL_BIT]),
    .vcoAboveThreshold(liveDrive[`VCO_ABOVE_BIT]),
    .secondRefAboveThreshold(liveDrive[`SECOND_REFERENCE_INPUT_ABOVE_BIT]),
    .firstRefAboveThreshold(liveDrive[`FIRST_REFERENCE_INPUT_ABOVE_BIT]),
    .digitalLockDetect(liveDrive[`LOCK_BIT]),
    .refThresholdSelect(refThresholdSelect),
    .irq(irq)
);

always #2.5 clk = ~clk;

////////////////////////////////////////////////////////////////////////////////

task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask

task automatic idle(input int n);
    repeat (n) @(posedge clk);
endtask

// every bus task starts and ends just after a rising edge, with one spare edge at the end
task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    bit awDone;
    bit wDone;
    awDone = 0;
    wDone = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
        @(posedge clk);
        if (!awDone && awready === 1'b1)
        begin
            awDone = 1;
            awvalid <= 1'b0;
        end
        if (!wDone && wready === 1'b1)
        begin
            wDone = 1;
            wvalid <= 1'b0;
        end
        if (bvalid === 1'b1)
        begin
            r = bresp;
            break;
        end
    end
    if (i == 50)
    begin
        err_count++;
        test_done();
    end
    bready <= 1'b0;
    @(posedge clk);
endtask

task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    r = 2'h3;
    d = '0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
        @(posedge clk);
        if (arready === 1'b1)
            arvalid <= 1'b0;
        if (rvalid === 1'b1)
        begin
            d = rdata;
            r = rresp;
            break;
        end
    end
    if (i == 50)
    begin
        err_count++;
        test_done();
    end
    rready <= 1'b0;
    @(posedge clk);
endtask

task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    `CHECK("read data", exp, d)
    `CHECK("read response", er, r)
endtask

////////////////////////////////////////////////////////////////////////////////

task automatic test_reset();
    read_check(CFG_ADDR, 32'h0, `RESP_OKAY);
    read_check(STAT_ADDR, 32'h0, `RESP_OKAY);
    read_check(IST_ADDR, 32'h0, `RESP_OKAY);
    read_check(IMSK_ADDR, 32'h0, `RESP_OKAY);
    `CHECK("threshold select", 1'b0, refThresholdSelect)
    `CHECK("irq", 1'b0, irq)
endtask

// one live bit at a time, then all, then none: catches swapped or inverted fields
task automatic test_live_bits();
    logic [4:0] pat;
    for (int b = 0; b < 7; b++)
    begin
        pat = (b < 5) ? 5'h01 << b : ((b == 5) ? 5'h1f : 5'h00);
        liveDrive <= pat;
        idle(4);
        read_check(STAT_ADDR, {27'h0, pat}, `RESP_OKAY);
    end
endtask

task automatic test_thresh();
    logic [1:0] r;
    axi_write(CFG_ADDR, 32'h40, r);
    `CHECK("cfg write response", `RESP_OKAY, r)
    `CHECK("threshold select", 1'b1, refThresholdSelect)
    read_check(CFG_ADDR, 32'h40, `RESP_OKAY);
    axi_write(CFG_ADDR, 32'hffffffbf, r);
    `CHECK("threshold select", 1'b0, refThresholdSelect)
    read_check(CFG_ADDR, 32'h0, `RESP_OKAY);
endtask

task automatic test_status_ro();
    logic [1:0] r;
    liveDrive <= 5'h15;
    axi_write(STAT_ADDR, 32'h0a, r);
    `CHECK("status write response", `RESP_OKAY, r)
    read_check(STAT_ADDR, 32'h15, `RESP_OKAY);
    axi_write(BAD_ADDR, 32'hff, r);
    `CHECK("unmapped write response", `RESP_SLVERR, r)
    read_check(BAD_ADDR, 32'h0, `RESP_SLVERR);
endtask

// events are latched even when masked; irq follows status and mask
task automatic test_irq();
    logic [1:0] r;
    liveDrive <= 5'h00;
    idle(4);
    axi_write(IST_ADDR, 32'h1f, r);
    read_check(IST_ADDR, 32'h0, `RESP_OKAY);
    liveDrive <= 5'h01;
    idle(4);
    read_check(IST_ADDR, 32'h01, `RESP_OKAY);
    `CHECK("irq masked", 1'b0, irq)
    axi_write(IMSK_ADDR, 32'h08, r);
    read_check(IMSK_ADDR, 32'h08, `RESP_OKAY);
    `CHECK("irq other bit", 1'b0, irq)
    liveDrive <= 5'h09;
    // two sync edges, one to flag, one to irq that launches the pin, plus one spare edge
    idle(5);
    `CHECK("irq enabled", 1'b1, irq)
    axi_write(IST_ADDR, 32'h08, r);
    idle(2);
    `CHECK("irq cleared", 1'b0, irq)
    read_check(IST_ADDR, 32'h01, `RESP_OKAY);
    axi_write(IMSK_ADDR, 32'h01, r);
    idle(2);
    `CHECK("irq unmasked", 1'b1, irq)
    axi_write(IST_ADDR, 32'h1f, r);
    idle(2);
    `CHECK("irq final", 1'b0, irq)
endtask

////////////////////////////////////////////////////////////////////////////////

initial
begin
    clk = 1'b0;
    rst_n = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    liveDrive = '0;
    err_count = 0;
    n_checks = 0;
    idle(2);
    rst_n <= 1'b1;
    idle(3);
    test_reset();
    test_live_bits();
    test_thresh();
    test_status_ro();
    test_irq();
    test_done();
end

endmodule
